/* File: logic/sro_pkg.sv */
// What this block does
// - clear-carry zeroes carry, advances program counter by one, nothing else changes
// - carry also loadable by status load and set-carry
// - subroutine exit loads program counter from stack top instead of incrementing
// - on the same edge as that load, subroutine exit pops the stack exactly one level
// - pop shifts the seven lower entries toward top, bottom kept, no underflow check
// - exit takes 2 cycles to RAM, 3 to ROM, 3+p external, plus fetch waits
// - clear and rotate ops repeatable: n cycles for n repeats, plus p external
// - clear sync mode zeroes frame-sync mode bit, advances program counter by one
// - sync mode zero: one receive sync pulse starts continuous reception
// - sync mode zero, internal sync source off: one transmit pulse starts transmitter
// - in continuous mode later sync input activity is ignored
// - continuous, sync source on: sync output pulses on first data write only
// - frame-sync mode bit also loadable by status load and set op
// - hold mode one: acknowledged hold halts instruction execution
// - hold mode zero: internal execution continues while external bus floats
// - hold mode bit also loadable by status load and set op
// - rotate left: bit 31 to carry, old carry into bit 0
// - rotate right: bit 0 to carry, old carry into bit 31
// - rotates ignore sign-extension mode and change no status bit but carry
`default_nettype none
package sro_pkg;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [15:0] OP_CLEAR_CARRY = 16'hCE30;
  localparam logic [15:0] OP_SUB_EXIT = 16'hCE26;
  localparam logic [15:0] OP_CLEAR_FSM = 16'hCE36;
  localparam logic [15:0] OP_CLEAR_HM = 16'hCE38;
  localparam logic [15:0] OP_ROTATE_LEFT = 16'hCE34;
  localparam logic [15:0] OP_ROTATE_RIGHT = 16'hCE35;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h08;
  localparam logic [7:0] ADDR_SET_BITS = 8'h0C;
  localparam logic [7:0] ADDR_ACC = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_STACK = 8'h18;
  localparam logic [7:0] ADDR_WAIT = 8'h1C;
  localparam logic [7:0] ADDR_TX_DATA = 8'h20;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_RPT_LSB = 16;
  localparam int CMD_EXT_BIT = 24;

  // status register one bit positions
  localparam int BIT_CARRY = 0;
  localparam int BIT_FSM = 1;
  localparam int BIT_HM = 2;
  localparam int BIT_TXM = 3;
  localparam int BIT_SXM = 4;
  localparam int ST1_WIDTH = 5;
  localparam logic [4:0] ST1_RESET = 5'h06;

  // ----------------------------------------
  // timing in core cycles
  // ----------------------------------------
  localparam logic [1:0] EXIT_RAM_CYCLES = 2'h2;
  localparam logic [1:0] EXIT_ROM_CYCLES = 2'h3;
  localparam logic [1:0] EXIT_EXT_CYCLES = 2'h3;

  typedef enum {
    S_IDLE,
    S_FETCH,
    S_RUN
  } sro_state_type;

  typedef struct packed {
    logic sign_extend_mode_bit;
    logic transmit_sync_source_bit;
    logic hm;
    logic fsm;
    logic carry;
  } sro_st1_type;

  typedef struct packed {
    logic extFetch;
    logic [7:0] repeatCount;
    logic [15:0] opcode;
  } sro_cmd_type;
endpackage : sro_pkg
`default_nettype wire

/* File: logic/sro_core.sv */
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sro_core
  import sro_pkg::*;
#(
  parameter int PC_WIDTH = 16,
  parameter int STACK_DEPTH = 8,
  parameter logic [15:0] RAM_LO = 16'hFF00,
  parameter logic [15:0] ROM_HI = 16'h0FFF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic holdReq,
  output logic holdAck,
  output logic extBusEnable,
  output logic execHalted,
  input wire logic rxFrameSyncIn,
  output logic rxWordStart,
  input wire logic txFrameSyncIn,
  output logic txFrameSyncOut,
  output logic txFrameSyncOe,
  output logic txWordStart
);
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  sro_state_type state;
  sro_st1_type st1;
  sro_cmd_type cmd;
  logic [31:0] acc;
  logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0] stack [STACK_DEPTH];
  logic [7:0] waitStates;
  logic [7:0] fetchLeft;
  logic [7:0] runLeft;
  logic [7:0] destWaitLeft;
  logic rxRunning;
  logic txRunning;
  logic rxSyncPrev;
  logic txSyncPrev;

  wire logic access = psel && penable;
  wire logic wrAccess = access && pwrite;
  wire logic hitCmd = paddr == ADDR_CMD;
  wire logic hitState = paddr == ADDR_STATE;
  wire logic hitSt1 = paddr == ADDR_STATUS_ONE;
  wire logic hitSet = paddr == ADDR_SET_BITS;
  wire logic hitAcc = paddr == ADDR_ACC;
  wire logic hitPc = paddr == ADDR_PC;
  wire logic hitStack = paddr == ADDR_STACK;
  wire logic hitWait = paddr == ADDR_WAIT;
  wire logic hitTx = paddr == ADDR_TX_DATA;
  wire logic mapped = hitCmd | hitState | hitSt1 | hitSet | hitAcc | hitPc | hitStack | hitWait | hitTx;
  wire logic [15:0] newOp = pwdata[CMD_OP_LSB +: 16];
  wire logic busy = state != S_IDLE;

  function automatic logic known_op(input logic [15:0] op);
    known_op = (op == OP_CLEAR_CARRY) || (op == OP_SUB_EXIT) || (op == OP_CLEAR_FSM)
      || (op == OP_CLEAR_HM) || (op == OP_ROTATE_LEFT) || (op == OP_ROTATE_RIGHT);
  endfunction : known_op

  // a command is refused while one is running or when the opcode is unknown
  wire logic cmdBad = hitCmd && (busy || !known_op(newOp));
  wire logic cmdTake = wrAccess && hitCmd && !cmdBad;
  wire logic st1Write = wrAccess && hitSt1;
  wire logic setWrite = wrAccess && hitSet;
  wire logic txWrite = wrAccess && hitTx;
  wire logic stackWrite = wrAccess && hitStack;

  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && cmdBad) || (!pwrite && (hitCmd || hitSet || hitTx)));

  always_comb begin
    prdata = 32'h0;
    if (access && !pwrite) begin
      if (hitState) begin
        prdata = {24'h0, 4'h0, execHalted, holdAck, txRunning && rxRunning, busy};
      end else if (hitSt1) begin
        prdata = {{(32 - ST1_WIDTH){1'b0}}, st1};
      end else if (hitAcc) begin
        prdata = acc;
      end else if (hitPc) begin
        prdata = {{(32 - PC_WIDTH){1'b0}}, pc};
      end else if (hitStack) begin
        prdata = {{(32 - PC_WIDTH){1'b0}}, stack[0]};
      end else if (hitWait) begin
        prdata = {24'h0, waitStates};
      end
    end
  end

  // ----------------------------------------
  // hold handling
  // ----------------------------------------
  // with hold mode clear only external fetches stall; internal code keeps running
  wire logic stall = holdAck && (st1.hm || cmd.extFetch);
  assign execHalted = holdAck && st1.hm;
  assign extBusEnable = !holdAck;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      holdAck <= 1'b0;
    end else begin
      holdAck <= holdReq;
    end
  end

  // ----------------------------------------
  // execution sequencer
  // ----------------------------------------
  wire logic isExit = cmd.opcode == OP_SUB_EXIT;
  wire logic [PC_WIDTH-1:0] stackTop = stack[0];
  wire logic destRam = stackTop >= RAM_LO;
  wire logic destRom = stackTop <= ROM_HI;
  wire logic [1:0] exitBase = destRam ? EXIT_RAM_CYCLES : (destRom ? EXIT_ROM_CYCLES : EXIT_EXT_CYCLES);
  wire logic lastStep = (state == S_RUN) && !stall && (runLeft == 8'h1) && (destWaitLeft == 8'h0);
  wire logic opStep = (state == S_RUN) && !stall && !isExit;
  wire logic newIsExit = newOp == OP_SUB_EXIT;
  // a repeat field of all ones wraps to zero, which the down-counter runs as 256 steps
  wire logic [7:0] firstRun = newIsExit ? {6'h0, exitBase} : pwdata[CMD_RPT_LSB +: 8] + 8'h1;
  wire logic [7:0] newExitWait = (newIsExit && !(destRam || destRom)) ? waitStates : 8'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      cmd <= '0;
      fetchLeft <= 8'h0;
      runLeft <= 8'h0;
      destWaitLeft <= 8'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (cmdTake) begin
            cmd <= pwdata[CMD_EXT_BIT:0];
            fetchLeft <= pwdata[CMD_EXT_BIT] ? waitStates : 8'h0;
            // the exit op cannot repeat; its repeat field is ignored, its length follows the destination
            runLeft <= firstRun;
            destWaitLeft <= newExitWait;
            state <= (pwdata[CMD_EXT_BIT] && waitStates != 8'h0) ? S_FETCH : S_RUN;
          end
        end
        S_FETCH: begin
          if (!stall) begin
            fetchLeft <= fetchLeft - 8'h1;
            if (fetchLeft == 8'h1) begin
              state <= S_RUN;
            end
          end
        end
        S_RUN: begin
          if (!stall) begin
            if (destWaitLeft != 8'h0) begin
              destWaitLeft <= destWaitLeft - 8'h1;
            end else begin
              runLeft <= runLeft - 8'h1;
              if (runLeft == 8'h1) begin
                state <= S_IDLE;
              end
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // accumulator, status, program counter
  // ----------------------------------------
  wire logic doRol = opStep && cmd.opcode == OP_ROTATE_LEFT && destWaitLeft == 8'h0;
  wire logic doRor = opStep && cmd.opcode == OP_ROTATE_RIGHT && destWaitLeft == 8'h0;
  wire logic doClc = opStep && cmd.opcode == OP_CLEAR_CARRY;
  wire logic doClf = opStep && cmd.opcode == OP_CLEAR_FSM;
  wire logic doClh = opStep && cmd.opcode == OP_CLEAR_HM;
  wire logic exitFires = lastStep && isExit;
  // load and pop share one edge so the top is read before it shifts
  wire logic exitDone = exitFires;

  sro_st1_type next_st1;
  always_comb begin
    next_st1 = st1;
    if (st1Write) begin
      next_st1 = pwdata[ST1_WIDTH-1:0];
    end else if (setWrite) begin
      next_st1 = st1 | pwdata[ST1_WIDTH-1:0];
    end
    if (doClc) begin
      next_st1.carry = 1'b0;
    end
    if (doClf) begin
      next_st1.fsm = 1'b0;
    end
    if (doClh) begin
      next_st1.hm = 1'b0;
    end
    if (doRol) begin
      next_st1.carry = acc[31];
    end
    if (doRor) begin
      next_st1.carry = acc[0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st1 <= ST1_RESET;
      acc <= 32'h0;
    end else begin
      st1 <= next_st1;
      if (doRol) begin
        acc <= {acc[30:0], st1.carry};
      end else if (doRor) begin
        acc <= {st1.carry, acc[31:1]};
      end else if (wrAccess && hitAcc) begin
        acc <= pwdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc <= '0;
    end else if (exitDone) begin
      pc <= stackTop;
    end else if (lastStep && !isExit) begin
      pc <= pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
    end else if (wrAccess && hitPc) begin
      pc <= pwdata[PC_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      waitStates <= 8'h0;
    end else if (wrAccess && hitWait) begin
      waitStates <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // hardware stack
  // ----------------------------------------
  // a write pushes so software can set up return addresses; bottom is lost on push
  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          stack[gi] <= '0;
        end else if (exitDone) begin
          if (gi < STACK_DEPTH - 1) begin
            stack[gi] <= stack[gi+1];
          end
        end else if (stackWrite) begin
          stack[gi] <= (gi == 0) ? pwdata[PC_WIDTH-1:0] : stack[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // serial framing
  // ----------------------------------------
  wire logic rxPulse = rxFrameSyncIn && !rxSyncPrev;
  wire logic txPulse = txFrameSyncIn && !txSyncPrev;
  wire logic rxStartNow = rxPulse && (st1.fsm || !rxRunning);
  wire logic txExtStart = !st1.transmit_sync_source_bit && txPulse && (st1.fsm || !txRunning);
  wire logic txIntStart = st1.transmit_sync_source_bit && txWrite && (st1.fsm || !txRunning);
  assign txFrameSyncOe = st1.transmit_sync_source_bit;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxSyncPrev <= 1'b0;
      txSyncPrev <= 1'b0;
      rxRunning <= 1'b0;
      txRunning <= 1'b0;
      rxWordStart <= 1'b0;
      txWordStart <= 1'b0;
      txFrameSyncOut <= 1'b0;
    end else begin
      rxSyncPrev <= rxFrameSyncIn;
      txSyncPrev <= txFrameSyncIn;
      rxWordStart <= rxStartNow;
      txWordStart <= txExtStart || txIntStart;
      txFrameSyncOut <= txIntStart;
      // leaving continuous mode re-arms the first-pulse detection
      rxRunning <= !st1.fsm && (rxRunning || rxPulse);
      txRunning <= !st1.fsm && (txRunning || txExtStart || txIntStart);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_clear_carry;
    @(posedge sys_clk) disable iff (!resetn)
    doClc && !st1Write && !setWrite |=> !st1.carry && $stable(acc);
  endproperty
  a_clear_carry: assert property (p_clear_carry) else $error("carry not cleared");

  property p_exit_pc;
    @(posedge sys_clk) disable iff (!resetn)
    exitDone |=> pc == $past(stack[0]) && stack[0] == $past(stack[1]);
  endproperty
  a_exit_pc: assert property (p_exit_pc) else $error("exit did not load and pop");

  property p_pop_bottom;
    @(posedge sys_clk) disable iff (!resetn)
    exitDone |=> stack[STACK_DEPTH-1] == stack[STACK_DEPTH-2];
  endproperty
  a_pop_bottom: assert property (p_pop_bottom) else $error("bottom entries differ after pop");

  property p_exit_ram_time;
    @(posedge sys_clk) disable iff (!resetn)
    cmdTake && newOp == OP_SUB_EXIT && !pwdata[CMD_EXT_BIT] && stack[0] >= RAM_LO && !holdAck && !holdReq
      |=> busy [*2] ##1 !busy;
  endproperty
  a_exit_ram_time: assert property (p_exit_ram_time) else $error("exit to ram not two cycles");

  property p_repeat_time;
    @(posedge sys_clk) disable iff (!resetn)
    cmdTake && newOp == OP_ROTATE_LEFT && !pwdata[CMD_EXT_BIT] && pwdata[CMD_RPT_LSB +: 8] == 8'h2
      && !holdAck && !holdReq ##1 !holdReq [*2] |=> busy ##1 !busy;
  endproperty
  a_repeat_time: assert property (p_repeat_time) else $error("three repeats not three cycles");

  property p_rol;
    @(posedge sys_clk) disable iff (!resetn)
    doRol |=> acc == {$past(acc[30:0]), $past(st1.carry)} && st1.carry == $past(acc[31]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");

  property p_ror;
    @(posedge sys_clk) disable iff (!resetn)
    doRor |=> acc == {$past(st1.carry), $past(acc[31:1])} && st1.carry == $past(acc[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_rot_only_carry;
    @(posedge sys_clk) disable iff (!resetn)
    (doRol || doRor) && !st1Write && !setWrite |=> st1[ST1_WIDTH-1:1] == $past(st1[ST1_WIDTH-1:1]);
  endproperty
  a_rot_only_carry: assert property (p_rot_only_carry) else $error("rotate touched other bits");

  property p_hold_halts;
    @(posedge sys_clk) disable iff (!resetn)
    holdAck && st1.hm && busy |=> $stable(pc) && $stable(acc) || $past(wrAccess);
  endproperty
  a_hold_halts: assert property (p_hold_halts) else $error("execution ran during hold");

  property p_rx_ignored;
    @(posedge sys_clk) disable iff (!resetn)
    rxRunning && !st1.fsm && rxPulse |=> !rxWordStart;
  endproperty
  a_rx_ignored: assert property (p_rx_ignored) else $error("sync pulse not ignored");

  property p_tx_once;
    @(posedge sys_clk) disable iff (!resetn)
    st1.transmit_sync_source_bit && !st1.fsm && txRunning && txWrite |=> !txFrameSyncOut;
  endproperty
  a_tx_once: assert property (p_tx_once) else $error("sync output pulsed again");
endmodule : sro_core
`default_nettype wire

/* File: dv/test_status_rotate_return_ops.sv */
`timescale 1ns/10ps
`default_nettype none
module test_status_rotate_return_ops
  import sro_pkg::*;
;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, acc, st;
  logic holdReq, holdAck, extBusEnable, execHalted;
  logic rxFrameSyncIn, rxWordStart, txFrameSyncIn, txFrameSyncOut, txFrameSyncOe, txWordStart;
  logic [15:0] lfsr, pc;
  logic [15:0] stk [8];
  logic [32:0] res;
  int fails, checksDone, rxCount, txCount, fsOutCount, r0, t0, f0;

  sro_core uut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .holdReq(holdReq), .holdAck(holdAck), .extBusEnable(extBusEnable), .execHalted(execHalted),
    .rxFrameSyncIn(rxFrameSyncIn), .rxWordStart(rxWordStart), .txFrameSyncIn(txFrameSyncIn),
    .txFrameSyncOut(txFrameSyncOut), .txFrameSyncOe(txFrameSyncOe), .txWordStart(txWordStart));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // pulse counters let a scenario compare how many word starts a burst of syncs produced
  always @(posedge sys_clk) begin
    if (rxWordStart === 1'b1) rxCount++;
    if (txWordStart === 1'b1) txCount++;
    if (txFrameSyncOut === 1'b1) fsOutCount++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
    return {lfsr, lfsr ^ 16'hA5C3};
  endfunction : rnd

  // returns {carry, acc} after n rotations
  function automatic logic [32:0] rot(input logic [31:0] a, input logic c, input logic left, input int n);
    for (int i = 0; i < n; i++) begin
      if (left) {c, a} = {a[31], a[30:0], c};
      else {a, c} = {c, a[31:1], a[0]};
    end
    return {c, a};
  endfunction : rot

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      give_verdict();
    end
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic runOp(input logic [15:0] op, input logic [7:0] rpt, input logic ext);
    int n;
    apb(1'b1, ADDR_CMD, {7'h00, ext, rpt, op});
    n = 0;
    do begin
      apb(1'b0, ADDR_STATE, 32'h0);
      n++;
    end while (rdv[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      fails++;
      give_verdict();
    end
  endtask : runOp

  task automatic syncPulses(input logic rx, input logic tx, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge sys_clk);
      rxFrameSyncIn <= rx;
      txFrameSyncIn <= tx;
      repeat (2) @(posedge sys_clk);
      rxFrameSyncIn <= 1'b0;
      txFrameSyncIn <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : syncPulses

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, holdReq, rxFrameSyncIn, txFrameSyncIn} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lfsr = 16'hF9C2;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, ADDR_STATUS_ONE, 32'h0);
    check("st1 after reset", rdv, {27'h0, ST1_RESET});
    check("bus enable idle", {31'h0, extBusEnable}, 32'h1);
    // rotates with random carry, sign mode and repeat counts; first one single, second long
    for (int i = 0; i < 8; i++) begin
      acc = rnd();
      st = rnd() & 32'h0000_001F;
      pc = 16'(rnd());
      apb(1'b1, ADDR_ACC, acc);
      apb(1'b1, ADDR_STATUS_ONE, st);
      apb(1'b1, ADDR_PC, {16'h0, pc});
      r0 = (i == 0) ? 0 : ((i == 1) ? 255 : ((i == 5) ? 2 : int'(rnd() & 32'h7)));
      runOp(i[0] ? OP_ROTATE_LEFT : OP_ROTATE_RIGHT, r0[7:0], i[1]);
      res = rot(acc, st[BIT_CARRY], i[0], r0 + 1);
      apb(1'b0, ADDR_ACC, 32'h0);
      check("rotated acc", rdv, res[31:0]);
      apb(1'b0, ADDR_STATUS_ONE, 32'h0);
      check("st1 after rotate", rdv, {st[31:1], res[32]});
      apb(1'b0, ADDR_PC, 32'h0);
      check("pc after rotate", rdv, {16'h0, pc + 16'h1});
    end
    // each clear op zeroes its own bit only; set register restores it
    apb(1'b1, ADDR_WAIT, 32'h3);
    for (int j = 0; j < 3; j++) begin
      acc = rnd();
      pc = 16'(rnd());
      apb(1'b1, ADDR_ACC, acc);
      apb(1'b1, ADDR_PC, {16'h0, pc});
      apb(1'b1, ADDR_STATUS_ONE, 32'h1F);
      runOp(j == 0 ? OP_CLEAR_CARRY : (j == 1 ? OP_CLEAR_FSM : OP_CLEAR_HM), j[7:0], j == 2);
      apb(1'b0, ADDR_STATUS_ONE, 32'h0);
      check("st1 after clear", rdv, 32'h1F & ~(32'h1 << j));
      apb(1'b0, ADDR_PC, 32'h0);
      check("pc after clear", rdv, {16'h0, pc + 16'h1});
      apb(1'b0, ADDR_ACC, 32'h0);
      check("acc after clear", rdv, acc);
      apb(1'b1, ADDR_SET_BITS, 32'h1 << j);
      apb(1'b0, ADDR_STATUS_ONE, 32'h0);
      check("st1 after set", rdv, 32'h1F);
    end
    // exits to RAM, ROM and external places; popping past the bottom repeats it
    for (int k = 0; k < 8; k++) begin
      pc = (k == 7) ? 16'hFF10 : ((k == 6) ? 16'h0100 : ((k == 5) ? 16'h5000 : 16'(rnd())));
      apb(1'b1, ADDR_STACK, {16'h0, pc});
      for (int m = 7; m > 0; m--) stk[m] = stk[m - 1];
      stk[0] = pc;
    end
    for (int k = 0; k < 9; k++) begin
      runOp(OP_SUB_EXIT, 8'h00, k == 2);
      apb(1'b0, ADDR_PC, 32'h0);
      check("pc after exit", rdv, {16'h0, stk[0]});
      for (int m = 0; m < 7; m++) stk[m] = stk[m + 1];
      apb(1'b0, ADDR_STACK, 32'h0);
      check("stack top after exit", rdv & 32'hFFFF, {16'h0, stk[0]});
    end
    apb(1'b1, ADDR_CMD, 32'h0000_1234);
    check("unknown opcode refused", {31'h0, lastErr}, 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped address", {31'h0, lastErr}, 32'h1);
    // internal sync source: pulse on every data write, then on the first only
    apb(1'b1, ADDR_STATUS_ONE, 32'h0A);
    @(posedge sys_clk);
    check("sync output enable", {31'h0, txFrameSyncOe}, 32'h1);
    f0 = fsOutCount;
    repeat (2) apb(1'b1, ADDR_TX_DATA, rnd());
    repeat (3) @(posedge sys_clk);
    check("sync outs frame mode", fsOutCount - f0, 32'd2);
    runOp(OP_CLEAR_FSM, 8'h00, 1'b0);
    f0 = fsOutCount;
    repeat (3) apb(1'b1, ADDR_TX_DATA, rnd());
    repeat (3) @(posedge sys_clk);
    check("sync outs continuous", fsOutCount - f0, 32'd1);
    // external syncs: each counts in frame mode, only the first in continuous mode
    apb(1'b1, ADDR_STATUS_ONE, 32'h02);
    r0 = rxCount;
    t0 = txCount;
    syncPulses(1'b1, 1'b1, 2);
    check("rx starts frame mode", rxCount - r0, 32'd2);
    check("tx starts frame mode", txCount - t0, 32'd2);
    runOp(OP_CLEAR_FSM, 8'h00, 1'b0);
    r0 = rxCount;
    t0 = txCount;
    syncPulses(1'b1, 1'b0, 1);
    syncPulses(1'b0, 1'b1, 1);
    syncPulses(1'b1, 1'b1, 3);
    check("rx starts continuous", rxCount - r0, 32'd1);
    check("tx starts continuous", txCount - t0, 32'd1);
    check("sync output released", {31'h0, txFrameSyncOe}, 32'h0);
    // hold with and without hold mode
    apb(1'b1, ADDR_STATUS_ONE, 32'h06);
    holdReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("halted in hold mode", {31'h0, execHalted}, 32'h1);
    check("hold acknowledged", {31'h0, holdAck}, 32'h1);
    // a command taken during a halting hold must stay pending
    apb(1'b1, ADDR_CMD, {16'h0000, OP_CLEAR_FSM});
    repeat (4) @(posedge sys_clk);
    apb(1'b0, ADDR_STATE, 32'h0);
    check("state in hold", rdv & 32'hD, 32'hD);
    apb(1'b0, ADDR_STATUS_ONE, 32'h0);
    check("no progress in hold", rdv, 32'h06);
    apb(1'b1, ADDR_STATUS_ONE, 32'h02);
    repeat (2) @(posedge sys_clk);
    check("running without hold mode", {31'h0, execHalted}, 32'h0);
    check("bus floated", {31'h0, extBusEnable}, 32'h0);
    apb(1'b0, ADDR_STATUS_ONE, 32'h0);
    check("pending op ran in hold", rdv, 32'h00);
    apb(1'b1, ADDR_ACC, 32'h8000_0001);
    runOp(OP_ROTATE_LEFT, 8'h00, 1'b0);
    apb(1'b0, ADDR_ACC, 32'h0);
    check("internal op during hold", rdv, 32'h0000_0002);
    holdReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("bus back", {31'h0, extBusEnable}, 32'h1);
    give_verdict();
  end
endmodule : test_status_rotate_return_ops
`default_nettype wire
